// file: logic/svrw_regs.svh
// Timing constants and the behaviour summary of the supervisor and watchdog block
// How it works
// - Reset stays active while supply is low, then until the hold timer expires.
// - Hold period lies between 140 ms and 400 ms, nominally 200 ms.
// - Timeout output goes low when the strobe does not change within the period.
// - Watchdog period lies between 1.00 s and 2.25 s, nominally 1.6 s.
// - Driving the manual reset input low starts a reset.
// - Reset output goes active within 5 us of manual reset going low.
// - An unconnected strobe input is serviced internally, so no timeout occurs.
// - A build parameter picks active-low or active-high reset output.
// - Power-fail warning output follows the secondary threshold comparator.
// - Any strobe edge, rising or falling, before timeout restarts the period count.
// - Watchdog counting begins only once the hold period has expired and reset is released.
// - Manual reset hold period counts from release of the input, not assertion.
// - While supply is low, the timeout output is forced low.
`ifndef SVRW_REGS_SVH
`define SVRW_REGS_SVH

`define SVRW_CLK_HZ 64'd10000000
`define SVRW_HOLD_MIN_MS 64'd140
`define SVRW_HOLD_NOM_MS 64'd200
`define SVRW_HOLD_MAX_MS 64'd400
`define SVRW_WD_MIN_MS 64'd1000
`define SVRW_WD_NOM_MS 64'd1600
`define SVRW_WD_MAX_MS 64'd2250
`define SVRW_MANUAL_PULSE_MIN_NS 64'd1000
`define SVRW_MANUAL_TO_RESET_DELAY_NS 64'd5000

`define SVRW_HOLD_NOM_CYC ((`SVRW_HOLD_NOM_MS * `SVRW_CLK_HZ) / 64'd1000)
`define SVRW_WD_NOM_CYC ((`SVRW_WD_NOM_MS * `SVRW_CLK_HZ) / 64'd1000)
`define SVRW_MANUAL_PULSE_MIN_CYC ((`SVRW_MANUAL_PULSE_MIN_NS * `SVRW_CLK_HZ) / 64'd1000000000)
`define SVRW_SYNC_STAGES 64'd2
`define SVRW_MANUAL_FILT_CYC (`SVRW_MANUAL_PULSE_MIN_CYC - `SVRW_SYNC_STAGES)

`endif

// file: logic/svrw_pkg.sv
// Types shared by the supervisor and watchdog block
package svrw_pkg;

  typedef enum logic [2:0] {
    SVRW_ST_RESET = 3'b001,
    SVRW_ST_HOLD = 3'b010,
    SVRW_ST_RUN = 3'b100
  } svrw_state_type;

endpackage

// file: logic/svrw_sync.sv
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/100ps
module svrw_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= INIT;
      sync_q <= INIT;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule

// file: logic/svrw_top.sv
// Supervisor: reset generator with hold timer, manual reset, watchdog and power-fail warning
`timescale 1ns/100ps
`include "svrw_regs.svh"
module svrw_top
  import svrw_pkg::*;
#(
  parameter int CNT_W = 25,
  parameter int HOLD_CYC = int'(`SVRW_HOLD_NOM_CYC),
  parameter int WD_CYC = int'(`SVRW_WD_NOM_CYC),
  parameter int MANUAL_FILT_CYC = int'(`SVRW_MANUAL_FILT_CYC),
  parameter bit RESET_ACTIVE_HIGH = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic supply_low_in,
  input wire logic manual_reset_n,
  input wire logic watchdog_strobe_in,
  output logic watchdog_strobe_out,
  output logic watchdog_strobe_oe,
  input wire logic powerfail_sense_in,
  output logic reset_out,
  output logic watchdog_timeout_out_n,
  output logic powerfail_warn_out
);

  // Elaboration checks: counters must hold the terminal values
  if (CNT_W < 4 || CNT_W > 30) begin : g_chk_w
    $error("svrw_top: CNT_W out of range");
  end
  if (HOLD_CYC < 2 || HOLD_CYC >= (1 << CNT_W)) begin : g_chk_hold
    $error("svrw_top: HOLD_CYC does not fit the counter");
  end
  // Below 32 the pulled pin cannot get through the synchroniser before expiry
  if (WD_CYC < 32 || WD_CYC >= (1 << CNT_W)) begin : g_chk_wd
    $error("svrw_top: WD_CYC does not fit the counter");
  end
  if (MANUAL_FILT_CYC < 1 || MANUAL_FILT_CYC > 255) begin : g_chk_filt
    $error("svrw_top: MANUAL_FILT_CYC out of range");
  end

  localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYC - 1);
  localparam logic [CNT_W-1:0] WD_LAST = CNT_W'(WD_CYC - 1);
  // Strobe pull goes high for the last eighth of the period
  localparam logic [CNT_W-1:0] PULL_HIGH_AT = CNT_W'(WD_CYC - (WD_CYC / 8));
  localparam logic [7:0] FILT_LAST = 8'(MANUAL_FILT_CYC - 1);

  function automatic logic [CNT_W-1:0] cnt_step(input logic [CNT_W-1:0] value,
                                                input logic [CNT_W-1:0] last);
    cnt_step = (value == last) ? value : value + CNT_W'(1);
  endfunction

  // Input synchronisation
  logic [3:0] raw_in;
  logic [3:0] sync_in;
  logic supply_low_s;
  logic manual_n_s;
  logic strobe_s;
  logic pf_below_s;

  assign raw_in = {supply_low_in, manual_reset_n, watchdog_strobe_in, powerfail_sense_in};

  // Supply-low and manual reset start asserted so reset holds through power-up
  svrw_sync #(
    .WIDTH(4),
    .INIT(4'b1000)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in(raw_in),
    .sync_out(sync_in)
  );

  assign supply_low_s = sync_in[3];
  assign manual_n_s = sync_in[2];
  assign strobe_s = sync_in[1];
  assign pf_below_s = sync_in[0];

  // Manual reset glitch filter
  // A low shorter than the filter is ignored; the filter is shorter than the
  // guaranteed minimum pulse so every legal press is caught.
  logic [7:0] filt_cnt_q;
  logic [7:0] filt_cnt_d;
  logic manual_act_q;
  logic manual_act_d;

  always_comb begin
    filt_cnt_d = filt_cnt_q;
    manual_act_d = manual_act_q;
    if (manual_n_s) begin
      filt_cnt_d = 8'h00;
      manual_act_d = 1'b0;
    end else if (filt_cnt_q == FILT_LAST) begin
      manual_act_d = 1'b1;
    end else begin
      filt_cnt_d = filt_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      filt_cnt_q <= 8'h00;
      manual_act_q <= 1'b0;
    end else begin
      filt_cnt_q <= filt_cnt_d;
      manual_act_q <= manual_act_d;
    end
  end

  // Reset sequencer
  svrw_state_type state_q;
  svrw_state_type state_d;
  logic [CNT_W-1:0] hold_cnt_q;
  logic [CNT_W-1:0] hold_cnt_d;
  logic rst_cond;
  logic reset_act_q;
  logic reset_act_d;

  // Immediate press recognition at the filter's last count keeps latency near 1 us
  assign rst_cond = supply_low_s | manual_act_d;

  always_comb begin
    state_d = state_q;
    hold_cnt_d = hold_cnt_q;
    unique case (state_q)
      SVRW_ST_RESET: begin
        hold_cnt_d = '0;
        if (!rst_cond) begin
          state_d = SVRW_ST_HOLD;
        end
      end
      SVRW_ST_HOLD: begin
        if (rst_cond) begin
          state_d = SVRW_ST_RESET;
          hold_cnt_d = '0;
        end else if (hold_cnt_q == HOLD_LAST) begin
          state_d = SVRW_ST_RUN;
        end else begin
          hold_cnt_d = cnt_step(hold_cnt_q, HOLD_LAST);
        end
      end
      SVRW_ST_RUN: begin
        if (rst_cond) begin
          state_d = SVRW_ST_RESET;
        end
      end
      default: begin
        state_d = SVRW_ST_RESET;
        hold_cnt_d = '0;
      end
    endcase
    reset_act_d = (state_d != SVRW_ST_RUN);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SVRW_ST_RESET;
      hold_cnt_q <= '0;
      reset_act_q <= 1'b1;
    end else begin
      state_q <= state_d;
      hold_cnt_q <= hold_cnt_d;
      reset_act_q <= reset_act_d;
    end
  end

  // Watchdog
  logic strobe_prev_q;
  logic strobe_prev_d;
  logic strobe_edge;
  logic [CNT_W-1:0] wd_cnt_q;
  logic [CNT_W-1:0] wd_cnt_d;
  logic wd_expired_q;
  logic wd_expired_d;
  logic pull_high_q;
  logic pull_high_d;
  logic wdo_n_q;
  logic wdo_n_d;

  assign strobe_edge = strobe_s ^ strobe_prev_q;

  always_comb begin
    strobe_prev_d = strobe_s;
    wd_cnt_d = wd_cnt_q;
    wd_expired_d = wd_expired_q;
    if (state_q != SVRW_ST_RUN) begin
      wd_cnt_d = '0;
      wd_expired_d = 1'b0;
    end else if (strobe_edge) begin
      wd_cnt_d = '0;
      wd_expired_d = 1'b0;
    end else if (wd_cnt_q == WD_LAST) begin
      wd_expired_d = 1'b1;
    end else begin
      wd_cnt_d = cnt_step(wd_cnt_q, WD_LAST);
    end
    // Weak pull pattern services a floating strobe pin before expiry
    pull_high_d = (wd_cnt_d >= PULL_HIGH_AT);
    wdo_n_d = !(supply_low_s || wd_expired_d);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      strobe_prev_q <= 1'b0;
      wd_cnt_q <= '0;
      wd_expired_q <= 1'b0;
      pull_high_q <= 1'b0;
      wdo_n_q <= 1'b0;
    end else begin
      strobe_prev_q <= strobe_prev_d;
      wd_cnt_q <= wd_cnt_d;
      wd_expired_q <= wd_expired_d;
      pull_high_q <= pull_high_d;
      wdo_n_q <= wdo_n_d;
    end
  end

  // Power-fail warning
  logic pf_warn_q;
  logic pf_warn_d;

  always_comb begin
    pf_warn_d = pf_below_s;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pf_warn_q <= 1'b0;
    end else begin
      pf_warn_q <= pf_warn_d;
    end
  end

  // Outputs
  // The strobe pull is weak: any outside driver overrides it
  assign watchdog_strobe_out = pull_high_q;
  assign watchdog_strobe_oe = 1'b1;
  assign reset_out = RESET_ACTIVE_HIGH ? reset_act_q : !reset_act_q;
  assign watchdog_timeout_out_n = wdo_n_q;
  assign powerfail_warn_out = pf_warn_q;

endmodule

// file: tb/svrw_checker.sv
// Port-level checks of the supervisor and watchdog block
`timescale 1ns/100ps
module svrw_checker #(
  parameter int HOLD_CYC = 50,
  parameter int WD_CYC = 160,
  parameter bit RESET_ACTIVE_HIGH = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic supply_low_in,
  input wire logic manual_reset_n,
  input wire logic watchdog_strobe_in,
  input wire logic powerfail_sense_in,
  input wire logic reset_out,
  input wire logic watchdog_timeout_out_n,
  input wire logic powerfail_warn_out
);
  int quiet_q;
  int wd_q;
  logic rst_act;
  // Reset seen as active-high whatever the build's polarity
  assign rst_act = RESET_ACTIVE_HIGH ? reset_out : !reset_out;
  // Cycles since any reset cause, and since the last strobe edge in run
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      quiet_q <= 0;
      wd_q <= 0;
    end else begin
      quiet_q <= (supply_low_in || !manual_reset_n) ? 0 : quiet_q + 1;
      wd_q <= (rst_act || $changed(watchdog_strobe_in)) ? 0 : wd_q + 1;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_supply_reset: assert property (supply_low_in [*5] |-> rst_act)
    else $error("reset not active under low supply");
  a_supply_timeout: assert property (supply_low_in [*5] |-> !watchdog_timeout_out_n)
    else $error("timeout output not forced under low supply");
  a_manual_delay: assert property ($fell(manual_reset_n) |-> ##[1:50] (rst_act || manual_reset_n))
    else $error("manual reset too slow");
  a_hold_min: assert property ($fell(rst_act) |-> quiet_q >= HOLD_CYC)
    else $error("reset released before hold period");
  a_hold_end: assert property (quiet_q == HOLD_CYC + 8 |-> !rst_act)
    else $error("reset held too long");
  a_wd_early: assert property ($fell(watchdog_timeout_out_n) && quiet_q > 4 |-> wd_q >= WD_CYC - 4)
    else $error("watchdog expired early");
  a_wd_late: assert property (wd_q == WD_CYC + 6 |-> !watchdog_timeout_out_n)
    else $error("watchdog did not expire");
  a_edge_clears: assert property (!watchdog_timeout_out_n && !rst_act && quiet_q > 4 &&
    $changed(watchdog_strobe_in) |-> ##[1:5] (watchdog_timeout_out_n || supply_low_in))
    else $error("strobe edge did not clear timeout");
  a_warn_follows: assert property (powerfail_warn_out == $past(powerfail_sense_in, 3))
    else $error("power-fail warning mismatch");
  c_expiry: cover property ($fell(watchdog_timeout_out_n));
  c_release: cover property ($fell(rst_act));
  c_manual: cover property ($fell(manual_reset_n));
endmodule
bind svrw_top svrw_checker #(.HOLD_CYC(HOLD_CYC), .WD_CYC(WD_CYC),
  .RESET_ACTIVE_HIGH(RESET_ACTIVE_HIGH)) chk (.clk_sys(clk_sys),
  .rst_n(rst_n), .supply_low_in(supply_low_in), .manual_reset_n(manual_reset_n),
  .watchdog_strobe_in(watchdog_strobe_in), .powerfail_sense_in(powerfail_sense_in),
  .reset_out(reset_out), .watchdog_timeout_out_n(watchdog_timeout_out_n),
  .powerfail_warn_out(powerfail_warn_out));

// file: tb/svrw_cpu_model.sv
// Processor model: takes the reset and toggles the watchdog strobe
`timescale 1ns/100ps
module svrw_cpu_model #(
  parameter int PER = 20
) (
  input wire logic clk_sys,
  input wire logic reset_out,
  input wire logic run,
  output logic strobe_drv
);
  int cnt;
  initial strobe_drv = 1'h0;
  initial cnt = 0;
  // Silent while held in reset or hung; each level lasts PER cycles, well over 50 ns
  always @(negedge clk_sys) begin
    if (!reset_out || !run) begin
      cnt <= 0;
    end else if (cnt == PER - 1) begin
      cnt <= 0;
      strobe_drv <= ~strobe_drv;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// file: tb/tb_supervisor_reset_watchdog.sv
// Self-checking bench for the supervisor and watchdog block
`timescale 1ns/100ps
module tb_supervisor_reset_watchdog;
  localparam int HOLD = 50;
  localparam int WD = 160;
  typedef struct packed {logic supply; logic sense; logic warn; logic rst; logic to_n;} svrw_row_type;
  svrw_row_type rows [3] = '{5'h0F, 5'h10, 5'h0D};
  logic clk_sys = 1'h0;
  logic rst_n = 1'h0;
  logic supply = 1'h0;
  logic man_n = 1'h1;
  logic sense = 1'h0;
  logic run = 1'h1;
  logic drive_en = 1'h1;
  logic strobe_drv, pin, wd_out, wd_oe, reset_out, to_n, warn, reset_hi;
  int miscompares = 0;
  int check_count = 0;
  int n;
  int lows;
  always #50 clk_sys = ~clk_sys;
  // Released pin falls back to the block's weak pull
  assign pin = drive_en ? strobe_drv : (wd_oe ? wd_out : 1'h0);
  svrw_top #(.HOLD_CYC(HOLD), .WD_CYC(WD)) uut (.clk_sys(clk_sys), .rst_n(rst_n),
    .supply_low_in(supply), .manual_reset_n(man_n), .watchdog_strobe_in(pin),
    .watchdog_strobe_out(wd_out), .watchdog_strobe_oe(wd_oe), .powerfail_sense_in(sense),
    .reset_out(reset_out), .watchdog_timeout_out_n(to_n), .powerfail_warn_out(warn));
  svrw_cpu_model #(.PER(20)) cpu (.clk_sys(clk_sys), .reset_out(reset_out), .run(run),
    .strobe_drv(strobe_drv));
  // Same inputs, other reset polarity build
  svrw_top #(.HOLD_CYC(HOLD), .WD_CYC(WD), .RESET_ACTIVE_HIGH(1'b1)) uut_hi (.clk_sys(clk_sys),
    .rst_n(rst_n), .supply_low_in(supply), .manual_reset_n(man_n), .watchdog_strobe_in(pin),
    .watchdog_strobe_out(), .watchdog_strobe_oe(), .powerfail_sense_in(sense),
    .reset_out(reset_hi), .watchdog_timeout_out_n(), .powerfail_warn_out());
  task check_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %b expected %b", $time, got, exp);
    end
  endtask
  task check_range(input int got, input int lo, input int hi);
    check_count++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("wrong value at %0t: %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task summarize;
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task wait_rst(input logic lvl);
    n = 0;
    while (reset_out !== lvl && n < 1000) begin
      @(negedge clk_sys);
      n++;
    end
  endtask
  task wait_to(input logic lvl);
    n = 0;
    while (to_n !== lvl && n < 1000) begin
      @(negedge clk_sys);
      n++;
    end
  endtask
  task watch(input int k);
    lows = 0;
    repeat (k) begin
      @(negedge clk_sys);
      if (to_n !== 1'h1) lows++;
    end
  endtask
  // About ten times the expected run, so a hang cannot pass
  initial begin
    #2000us;
    miscompares++;
    summarize;
  end
  initial begin
    repeat (12) @(negedge clk_sys);
    check_bit(reset_out, 1'h0);
    check_bit(reset_hi, 1'h1);
    rst_n = 1'h1;
    wait_rst(1'h1);
    check_range(n, HOLD, HOLD + 10);
    check_bit(reset_hi, 1'h0);
    $display("power-up finished");
    foreach (rows[i]) begin
      supply = rows[i].supply;
      sense = rows[i].sense;
      repeat (6) @(negedge clk_sys);
      check_bit(warn, rows[i].warn);
      check_bit(reset_out, rows[i].rst);
      check_bit(reset_hi, !rows[i].rst);
      check_bit(to_n, rows[i].to_n);
      $display("row %0d finished", i);
    end
    wait_rst(1'h1);
    check_range(n + 6, HOLD, HOLD + 10);
    man_n = 1'h0;
    wait_rst(1'h0);
    check_range(n, 1, 50);
    // Low for well over 1 us before release
    repeat (20) @(negedge clk_sys);
    man_n = 1'h1;
    wait_rst(1'h1);
    check_range(n, HOLD, HOLD + 10);
    $display("manual reset finished");
    watch(3 * WD);
    check_range(lows, 0, 0);
    @(strobe_drv);
    run = 1'h0;
    wait_to(1'h0);
    check_range(n, WD, WD + 8);
    run = 1'h1;
    wait_to(1'h1);
    check_range(n, 1, 26);
    $display("expiry finished");
    drive_en = 1'h0;
    watch(3 * WD);
    check_range(lows, 0, 0);
    drive_en = 1'h1;
    run = 1'h0;
    man_n = 1'h0;
    watch(WD + 20);
    check_range(lows, 0, 0);
    $display("float and hold finished");
    summarize;
  end
endmodule
